/* design/phase_gain_pkg.sv */
package phase_gain_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] GAIN_IDX     = 8'h0b;
  localparam logic [7:0] FINE_IDX     = 8'h0e;
  localparam logic [7:0] COARSE_IDX   = 8'h0f;
  localparam logic [7:0] STATUS_IDX   = 8'h10;
  localparam logic [7:0] APPLIED_IDX  = 8'h11;
  localparam logic [7:0] ANALOG_IDX   = 8'h12;
  localparam int         ADDR_W       = 8;
  // reset values
  localparam logic [15:0] GAIN_RST    = 16'h807f;
  localparam logic [15:0] FINE_RST    = 16'h00ff;
  localparam logic [15:0] COARSE_RST  = 16'h007f;
  localparam logic [9:0]  FS_RST_MV   = 10'd700;
  // must-be-one filler bits
  localparam logic [15:0] GAIN_FILL   = 16'h007f;
  localparam logic [15:0] FINE_FILL   = 16'h00ff;
  localparam logic [15:0] COARSE_FILL = 16'h007f;
  // field positions
  localparam int GAIN_LSB   = 7;
  localparam int FINE_LSB   = 8;
  localparam int INV_BIT    = 15;
  localparam int COARSE_LSB = 10;
  localparam int INTER_LSB  = 7;
  // status bits
  localparam int ST_GAIN_FILL   = 0;
  localparam int ST_FINE_FILL   = 1;
  localparam int ST_COARSE_FILL = 2;
  localparam int ST_PARTIAL     = 3;
  // analog model figures
  localparam logic [9:0]  FS_MIN_MV   = 10'd560;
  localparam logic [9:0]  FS_SPAN_MV  = 10'd280;
  localparam logic [6:0]  COARSE_PS   = 7'd65;
  localparam logic [6:0]  INTER_PS    = 7'd11;
endpackage

/* design/delay_sum.sv */
`timescale 1ns/1ps
`default_nettype none
module delay_sum
  import phase_gain_pkg::*;
(
  input  wire logic        pclk,        // bus clock
  input  wire logic        presetn,     // async reset, active low
  input  wire logic [4:0]  coarse_code, // coarse steps
  input  wire logic [2:0]  inter_code,  // intermediate steps
  output logic      [11:0] delay_ps     // summed delay estimate
);
  wire [11:0] coarse_ps = 12'(coarse_code) * 12'(COARSE_PS);
  wire [11:0] inter_ps  = 12'(inter_code) * 12'(INTER_PS);
  wire [11:0] sum_nxt   = 12'(coarse_ps + inter_ps);

  // worst case 31*65 + 7*11 = 2092 ps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      delay_ps <= 12'h000;
    else
      delay_ps <= sum_nxt; // R13
  end
endmodule
`default_nettype wire

/* design/adc_gain_phase_adjust_regs.sv */
// Notes on behaviour
// R1 - the second channel gain register sits at index 0xb, write only, and the host fills bits 6:0 with ones.
// R2 - bits 15:7 of the gain register form a nine-bit unsigned gain code applied linearly and monotonically.
// R3 - the gain code spans 560 mV at zero, 700 mV at midscale and 840 mV at all ones; fs_of gives 839 mV at 0x1ff.
// R4 - after reset the gain code is midscale, which is no adjustment.
// R5 - the host should keep the gain code between 0x0c0 and 0x1c0 to leave headroom.
// R6 - a gain change never starts or needs a recalibration.
// R7 - the fine phase register sits at index 0xe, resets to 0x00ff, and the host fills bits 7:0 with ones.
// R8 - bits 15:8 of the fine phase register are a monotonic delay code that resets to zero.
// R9 - the coarse phase register sits at index 0xf, resets to 0x007f, and the host fills bits 6:0 with ones.
// R10 - bit 15 of the coarse phase register inverts the sample clock and resets to zero.
// R11 - bits 14:10 are a coarse delay code of about 65 ps a step, zero at reset.
// R12 - bits 9:7 are an intermediate delay code of about 11 ps a step, zero at reset.
// R13 - coarse and intermediate codes together reach about 2.1 ns.
// R14 - the host should use the smallest phase delay it needs and check the benefit.
// R15 - fields change only when a complete 16-bit write to the register is accepted.
`timescale 1ns/1ps
`default_nettype none
module adc_gain_phase_adjust_regs
  import phase_gain_pkg::*;
(
  input  wire logic        pclk,                    // 250 MHz bus clock
  input  wire logic        presetn,                 // async reset, active low
  input  wire logic        psel,                    // apb select
  input  wire logic        penable,                 // apb enable
  input  wire logic        pwrite,                  // apb direction
  input  wire logic [9:0]  paddr,                   // apb byte address
  input  wire logic [31:0] pwdata,                  // apb write data
  input  wire logic [3:0]  pstrb,                   // apb byte strobes
  output logic             pready,                  // apb ready
  output logic      [31:0] prdata,                  // apb read data
  output logic             pslverr,                 // apb error
  output logic      [8:0]  gain_code,               // second channel gain trim
  output logic      [9:0]  fullscale_mv,            // full scale estimate
  output logic      [7:0]  fine_delay_code,         // fine sample clock delay
  output logic             sample_clock_invert,     // sample clock polarity
  output logic      [4:0]  coarse_delay_code,       // coarse sample clock delay
  output logic      [2:0]  intermediate_delay_code, // intermediate delay
  output logic      [11:0] total_delay_ps           // coarse plus intermediate
);
  logic [15:0] gain_r;
  logic [15:0] fine_r;
  logic [15:0] coarse_r;
  logic [3:0]  status_r;
  logic [3:0]  status_nxt;
  logic [9:0]  fs_r;
  logic        ready_r;
  logic [31:0] rdata_r;
  logic        err_r;

  function automatic logic is_idx(input logic [9:0] a, input logic [7:0] idx);
    is_idx = (a[1:0] == 2'b00) && (a[9:2] == idx);
  endfunction

  function automatic logic fill_bad(input logic [15:0] d, input logic [15:0] m);
    fill_bad = ((d & m) != m);
  endfunction

  // linear, monotonic: 0 -> 560, 0x100 -> 700, 0x1ff -> 839
  function automatic logic [9:0] fs_of(input logic [8:0] code);
    logic [18:0] prod;
    prod   = 19'(code) * 19'(FS_SPAN_MV);
    fs_of  = 10'(FS_MIN_MV + 10'(prod >> 9));
  endfunction

  // decode
  wire setup_ph   = psel && !penable;
  wire done       = psel && penable && ready_r;
  wire wr_done    = done && pwrite;
  wire sel_gain   = is_idx(paddr, GAIN_IDX);
  wire sel_fine   = is_idx(paddr, FINE_IDX);
  wire sel_coarse = is_idx(paddr, COARSE_IDX);
  wire sel_status = is_idx(paddr, STATUS_IDX);
  wire sel_appl   = is_idx(paddr, APPLIED_IDX);
  wire sel_analog = is_idx(paddr, ANALOG_IDX);
  wire mapped     = sel_gain | sel_fine | sel_coarse | sel_status | sel_appl | sel_analog;
  wire word_write = (pstrb[1:0] == 2'b11);
  wire partial    = pwrite && !word_write && (sel_gain | sel_fine | sel_coarse);
  wire full_wr    = wr_done && word_write;
  wire wr_gain    = full_wr && sel_gain;   // R15
  wire wr_fine    = full_wr && sel_fine;   // R15
  wire wr_coarse  = full_wr && sel_coarse; // R15
  wire [15:0] wd  = pwdata[15:0];

  // sticky warnings; set wins over write-one-to-clear
  wire [3:0] st_set = {wr_done && partial,
                       wr_coarse && fill_bad(wd, COARSE_FILL),
                       wr_fine && fill_bad(wd, FINE_FILL),
                       wr_gain && fill_bad(wd, GAIN_FILL)};
  wire [3:0] st_clr = (full_wr && sel_status) ? pwdata[3:0] : 4'h0;
  assign status_nxt = (status_r & ~st_clr) | st_set;

  wire [31:0] appl_word = {6'h00, coarse_r[INV_BIT], coarse_r[INTER_LSB +: 3],
                           coarse_r[COARSE_LSB +: 5], fine_r[FINE_LSB +: 8], gain_r[GAIN_LSB +: 9]};
  wire [31:0] analog_word = {6'h00, fs_r, 4'h0, total_delay_ps};
  // trim registers are write only and read back as zero
  wire [31:0] rd_mux = sel_status ? {28'h0000000, status_r} :
                       sel_appl   ? appl_word :
                       sel_analog ? analog_word : 32'h00000000;

  // one wait-free access phase: ready rises for the cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ready_r <= 1'b0;
    else
      ready_r <= setup_ph;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_r <= 32'h00000000;
    else
      rdata_r <= (setup_ph && !pwrite) ? rd_mux : 32'h00000000;
  end

  // errors are decided at setup so that they stand together with ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_r <= 1'b0;
    else
      err_r <= setup_ph && (!mapped || partial);
  end

  // partial strobes leave the old trim untouched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gain_r <= GAIN_RST;     // R4
    else if (wr_gain)
      gain_r <= wd;           // R1
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fine_r <= FINE_RST;     // R7
    else if (wr_fine)
      fine_r <= wd;           // R7
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      coarse_r <= COARSE_RST; // R9
    else if (wr_coarse)
      coarse_r <= wd;         // R9
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_r <= 4'h0;
    else
      status_r <= status_nxt;
  end

  // gain is a static trim; nothing here reaches calibration control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fs_r <= FS_RST_MV;
    else
      fs_r <= fs_of(gain_r[GAIN_LSB +: 9]); // R3 R6
  end

  delay_sum u_delay_sum
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .coarse_code (coarse_r[COARSE_LSB +: 5]),
    .inter_code  (coarse_r[INTER_LSB +: 3]),
    .delay_ps    (total_delay_ps)
  );

  assign pready                  = ready_r;
  assign prdata                  = rdata_r;
  assign pslverr                 = err_r;
  assign gain_code               = gain_r[GAIN_LSB +: 9];       // R2
  assign fullscale_mv            = fs_r;
  assign fine_delay_code         = fine_r[FINE_LSB +: 8];       // R8
  assign sample_clock_invert     = coarse_r[INV_BIT];           // R10
  assign coarse_delay_code       = coarse_r[COARSE_LSB +: 5];   // R11
  assign intermediate_delay_code = coarse_r[INTER_LSB +: 3];    // R12

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // marks the first edge after reset, where every reset value must still stand
  logic seen_edge;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seen_edge <= 1'b0;
    else
      seen_edge <= 1'b1;
  end

  // reset values
  AST_GAIN_RESET: assert property (!seen_edge |-> gain_code == 9'h100 && fullscale_mv == FS_RST_MV) // R4
    else $error("gain code not midscale after reset");

  AST_PHASE_RESET: assert property (!seen_edge |-> fine_delay_code == 8'h00 && coarse_delay_code == 5'h00
                                    && intermediate_delay_code == 3'h0 && !sample_clock_invert) // R8
    else $error("phase codes not zero after reset");

  AST_DELAY_RESET: assert property (!seen_edge |-> total_delay_ps == 12'h000) // R11
    else $error("delay estimate not zero after reset");

  // trims move on a complete write and on nothing else
  AST_GAIN_WRITE: assert property (psel && penable && pready && pwrite && pstrb[1:0] == 2'b11
                                   && paddr == 10'h02c |=> gain_code == $past(pwdata[15:7])) // R1
    else $error("gain write not applied");

  AST_FINE_WRITE: assert property (psel && penable && pready && pwrite && pstrb[1:0] == 2'b11
                                   && paddr == 10'h038 |=> fine_delay_code == $past(pwdata[15:8])) // R8
    else $error("fine write not applied");

  AST_COARSE_WRITE: assert property (psel && penable && pready && pwrite && pstrb[1:0] == 2'b11
                                     && paddr == 10'h03c |=> sample_clock_invert == $past(pwdata[15])
                                     && coarse_delay_code == $past(pwdata[14:10])
                                     && intermediate_delay_code == $past(pwdata[9:7])) // R10
    else $error("coarse write not applied");

  AST_GAIN_STEADY: assert property (!(psel && penable && pready && pwrite && pstrb[1:0] == 2'b11
                                      && paddr == 10'h02c) |=> $stable(gain_code)) // R15
    else $error("gain code moved without a complete write");

  AST_FINE_STEADY: assert property (!(psel && penable && pready && pwrite && pstrb[1:0] == 2'b11
                                      && paddr == 10'h038) |=> $stable(fine_delay_code)) // R15
    else $error("fine code moved without a complete write");

  AST_COARSE_STEADY: assert property (!(psel && penable && pready && pwrite && pstrb[1:0] == 2'b11
                                        && paddr == 10'h03c) |=> $stable(sample_clock_invert)
                                        && $stable(coarse_delay_code)
                                        && $stable(intermediate_delay_code)) // R15
    else $error("coarse trims moved without a complete write");

  AST_PARTIAL_KEEP: assert property (psel && penable && pready && pwrite && pstrb[1:0] != 2'b11
                                     |=> $stable(gain_code) && $stable(fine_delay_code)
                                     && $stable(coarse_delay_code)) // R15
    else $error("partial write changed a trim");

  // bus answer
  AST_PARTIAL_ERR: assert property (psel && !penable && pwrite && pstrb[1:0] != 2'b11 && paddr == 10'h02c
                                    |=> pready && pslverr) // R15
    else $error("partial write not refused");

  AST_UNALIGNED_ERR: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pready && pslverr) // R15
    else $error("unaligned access not refused");

  AST_WO_READ_ZERO: assert property (psel && !penable && !pwrite
                                     && (paddr == 10'h02c || paddr == 10'h038 || paddr == 10'h03c)
                                     |=> prdata == 32'h00000000 && !pslverr) // R1
    else $error("write only trim read back");

  AST_READY_ONE: assert property (psel && !penable |=> pready ##1 !pready) // R15
    else $error("ready timing wrong");

  AST_ERR_WITH_READY: assert property (pslverr |-> pready) // R15
    else $error("error without ready");

  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h00000000) // R1
    else $error("read data outside access");

  AST_STATUS_READ: assert property (psel && !penable && !pwrite && paddr == 10'h040
                                    |=> prdata == {28'h0000000, $past(status_r)}) // R15
    else $error("status read wrong");

  AST_APPLIED_READ: assert property (psel && !penable && !pwrite && paddr == 10'h044
                                     |=> prdata[8:0] == $past(gain_code)
                                     && prdata[16:9] == $past(fine_delay_code)) // R2
    else $error("applied view wrong");

  AST_ANALOG_READ: assert property (psel && !penable && !pwrite && paddr == 10'h048
                                    |=> prdata[11:0] == $past(total_delay_ps)
                                    && prdata[25:16] == $past(fullscale_mv)) // R13
    else $error("analog view wrong");

  // warning flags
  AST_STATUS_PARTIAL: assert property (psel && penable && pready && pwrite && pstrb[1:0] != 2'b11
                                       && paddr == 10'h03c |=> status_r[ST_PARTIAL]) // R15
    else $error("refused partial write not flagged");

  AST_STATUS_KEEP: assert property (status_r[ST_PARTIAL] && !(psel && penable && pready && pwrite
                                    && pstrb[1:0] == 2'b11 && paddr == 10'h040 && pwdata[ST_PARTIAL])
                                    |=> status_r[ST_PARTIAL]) // R15
    else $error("partial flag lost without a clear");

  AST_FINE_FILL: assert property (psel && penable && pready && pwrite && pstrb[1:0] == 2'b11
                                  && paddr == 10'h038 && pwdata[7:0] != 8'hff
                                  |=> status_r[ST_FINE_FILL]) // R7
    else $error("fine filler bits not flagged");

  // analog estimates lag the codes by one cycle
  AST_FS_TRACK: assert property ($changed(gain_code) ##1 $stable(gain_code)
                                 |-> fullscale_mv
                                 == 10'(FS_MIN_MV + 10'((19'(gain_code) * 19'(FS_SPAN_MV)) >> 9))) // R3
    else $error("full scale estimate wrong");

  AST_FS_RANGE: assert property (fullscale_mv >= FS_MIN_MV && fullscale_mv <= 10'(FS_MIN_MV + FS_SPAN_MV)) // R3
    else $error("full scale estimate out of range");

  AST_DELAY_SUM: assert property ($stable(coarse_delay_code) && $stable(intermediate_delay_code)
                                  |=> total_delay_ps == 12'(12'($past(coarse_delay_code)) * 12'(COARSE_PS)
                                  + 12'($past(intermediate_delay_code)) * 12'(INTER_PS))) // R13
    else $error("delay sum wrong");

  COV_GAIN_WR:   cover property (wr_gain);
  COV_COARSE_WR: cover property (wr_coarse && wd[INV_BIT]);
  COV_PARTIAL:   cover property (wr_done && partial);
  COV_STAT_CLR:  cover property (full_wr && sel_status && status_r != 4'h0);
  COV_UNALIGN:   cover property (psel && !penable && paddr[1:0] != 2'b00);
endmodule
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import phase_gain_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_clock_invert, er;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [8:0]  gain_code;
  logic [9:0]  fullscale_mv;
  logic [7:0]  fine_delay_code;
  logic [4:0]  coarse_delay_code;
  logic [2:0]  intermediate_delay_code;
  logic [11:0] total_delay_ps;
  int          miscompares, samples_checked;
  // extremes first, then two codes inside the recommended headroom range
  logic [8:0]  gcodes [4] = '{9'h000, 9'h1ff, 9'h1c0, 9'h0c0};

  adc_gain_phase_adjust_regs adc_gain_phase_adjust_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .gain_code(gain_code), .fullscale_mv(fullscale_mv),
    .fine_delay_code(fine_delay_code), .sample_clock_invert(sample_clock_invert),
    .coarse_delay_code(coarse_delay_code), .intermediate_delay_code(intermediate_delay_code),
    .total_delay_ps(total_delay_ps));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one apb transfer; waits for pready, not for a fixed count
  task automatic apb(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s, input logic w);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // analog estimates lag the codes by one cycle, so let two edges pass
  task automatic chk_out(input logic [8:0] g, input logic [7:0] f, input logic i, input logic [4:0] c,
                         input logic [2:0] m);
    repeat (2) @(posedge pclk);
    #1;
    check("gain", gain_code, g);
    check("fullscale", fullscale_mv, 560 + (int'(g) * 280) / 512);
    check("fine", fine_delay_code, f);
    check("invert", sample_clock_invert, i);
    check("coarse", coarse_delay_code, c);
    check("inter", intermediate_delay_code, m);
    check("total", total_delay_ps, int'(c) * 65 + int'(m) * 11);
  endtask

  task automatic t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_out(9'h100, 8'h00, 1'b0, 5'h00, 3'h0);
  endtask

  task automatic t_gain();
    foreach (gcodes[k])
    begin
      apb(10'h02c, {16'h0, gcodes[k], 7'h7f}, 4'hf, 1'b1);
      check("gain_err", er, 1'b0);
      chk_out(gcodes[k], 8'h00, 1'b0, 5'h00, 3'h0);
    end
  endtask

  task automatic t_phase();
    apb(10'h038, 32'h0000_a5ff, 4'hf, 1'b1);
    chk_out(9'h0c0, 8'ha5, 1'b0, 5'h00, 3'h0);
    apb(10'h03c, {16'h0, 1'b1, 5'h1f, 3'h7, 7'h7f}, 4'hf, 1'b1);
    chk_out(9'h0c0, 8'ha5, 1'b1, 5'h1f, 3'h7);
    apb(10'h03c, {16'h0, 1'b0, 5'h0a, 3'h2, 7'h7f}, 4'hf, 1'b1);
    chk_out(9'h0c0, 8'ha5, 1'b0, 5'h0a, 3'h2);
  endtask

  // partial and misdirected writes must leave every trim alone
  task automatic t_refuse();
    apb(10'h02c, 32'h0000_ff7f, 4'h1, 1'b1);
    check("part_err", er, 1'b1);
    apb(10'h03c, 32'h0000_ffff, 4'hc, 1'b1);
    check("part_err2", er, 1'b1);
    apb(10'h300, 32'h0000_ffff, 4'hf, 1'b1);
    check("unmap_err", er, 1'b1);
    chk_out(9'h0c0, 8'ha5, 1'b0, 5'h0a, 3'h2);
    apb(10'h038, 32'h0, 4'h0, 1'b0);
    check("wo_read", rd, 32'h0);
    check("wo_err", er, 1'b0);
    apb(10'h03a, 32'h0, 4'h0, 1'b0);
    check("unmap_rd", rd, 32'h0);
    check("unmap_rd_err", er, 1'b1);
  endtask

  // warning flags, write-one-to-clear and the read-back views of the trims
  task automatic t_status();
    apb(10'h040, 32'h0, 4'h0, 1'b0);
    check("st_part", rd, 32'h0000_0008);
    apb(10'h038, 32'h0000_a500, 4'hf, 1'b1);
    check("fill_err", er, 1'b0);
    apb(10'h040, 32'h0, 4'h0, 1'b0);
    check("st_fill", rd, 32'h0000_000a);
    apb(10'h040, 32'h0000_000a, 4'hf, 1'b1);
    apb(10'h040, 32'h0, 4'h0, 1'b0);
    check("st_clr", rd, 32'h0);
    apb(10'h044, 32'h0, 4'h0, 1'b0);
    check("applied", rd, {6'h00, 1'b0, 3'h2, 5'h0a, 8'ha5, 9'h0c0});
    apb(10'h048, 32'h0, 4'h0, 1'b0);
    check("analog", rd, {6'h00, 10'd665, 4'h0, 12'd672});
    apb(10'h03c, 32'h0000_007f, 4'hf, 1'b1);
    chk_out(9'h0c0, 8'ha5, 1'b0, 5'h00, 3'h0);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 10'h000;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    t_reset();
    t_gain();
    t_phase();
    t_refuse();
    t_status();
    t_reset();
    final_report();
  end

  initial
  begin
    #20000;
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
